// ---- rtl/adcp_top.sv ----
// Converter control, result registers and AXI4-Lite register port.
// Assumes an external analog mux, DAC and comparator driven from the pins.
//
// Function
// - Four read-only 16-bit result registers
// - Result left-justified in bits 15..6
// - Low six result bits read zero
// - Upper byte readable directly over byte path
// - Upper-byte read latches low byte
// - Results clear to zero on reset
// - Input position in group selects register
// - Any of eight inputs selectable
// - Single mode converts once then stops
// - Scan mode cycles one to four inputs
// - Start by software or external trigger
// - Interrupt request on conversion end
// - At least 3.5 us per conversion
`timescale 1ns/1ps
module adcp_top
   import adcp_pkg::*;
(
   // Clock and reset
   input  wire logic                MCLK,
   input  wire logic                RST_N,
   // AXI4-Lite write channels
   input  wire logic [ADDR_W-1:0]   S_AXI_AWADDR,
   input  wire logic                S_AXI_AWVALID,
   output logic                     S_AXI_AWREADY,
   input  wire logic [31:0]         S_AXI_WDATA,
   input  wire logic [3:0]          S_AXI_WSTRB,
   input  wire logic                S_AXI_WVALID,
   output logic                     S_AXI_WREADY,
   output logic [1:0]               S_AXI_BRESP,
   output logic                     S_AXI_BVALID,
   input  wire logic                S_AXI_BREADY,
   // AXI4-Lite read channels
   input  wire logic [ADDR_W-1:0]   S_AXI_ARADDR,
   input  wire logic                S_AXI_ARVALID,
   output logic                     S_AXI_ARREADY,
   output logic [31:0]              S_AXI_RDATA,
   output logic [1:0]               S_AXI_RRESP,
   output logic                     S_AXI_RVALID,
   input  wire logic                S_AXI_RREADY,
   // Analog front end and trigger
   input  wire logic                EXT_TRIGGER,
   input  wire logic                COMPARATOR,
   output logic [RES_BITS-1:0]      DAC_CODE,
   output logic [2:0]               ANALOG_SELECT,
   output logic                     SAMPLE_HOLD,
   // Interrupt
   output logic                     CONVERSION_DONE_INTERRUPT
);

   // ----------------------------------------------------------------
   // Decode shared by read and write paths
   // ----------------------------------------------------------------
   function automatic adcp_kind_e addr_kind(input logic [ADDR_W-1:0] a);
      if (a[1:0] != 2'b00)                    addr_kind = KIND_NONE;
      else if ((a & GROUP_MASK) == OFS_RESULT_A) addr_kind = KIND_WORD;
      else if ((a & GROUP_MASK) == OFS_UPPER_A)  addr_kind = KIND_UPPER;
      else if ((a & GROUP_MASK) == OFS_LOWER_A)  addr_kind = KIND_LOWER;
      else if (a == OFS_CONTROL)              addr_kind = KIND_CTRL;
      else if (a == OFS_STATUS)               addr_kind = KIND_STAT;
      else                                    addr_kind = KIND_NONE;
   endfunction

   function automatic logic [1:0] addr_index(input logic [ADDR_W-1:0] a);
      addr_index = a[IDX_LSB +: 2];
   endfunction

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic       trig_meta, trig_sync, trig_prev;
   logic       comp_meta, comp_sync;

   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         trig_meta <= 1'b0;
         trig_sync <= 1'b0;
         trig_prev <= 1'b0;
         comp_meta <= 1'b0;
         comp_sync <= 1'b0;
      end else begin
         trig_meta <= EXT_TRIGGER;
         trig_sync <= trig_meta;
         trig_prev <= trig_sync;
         comp_meta <= COMPARATOR;
         comp_sync <= comp_meta;
      end
   end

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [15:0]       results [NUM_RESULTS];
   logic [7:0]        low_latch;
   logic [2:0]        chan_cfg;
   logic              scan_mode, trig_en, irq_en;
   logic              running, done_flag;
   logic [2:0]        cur_chan;
   logic              start_q;

   adcp_conv_if conv ();

   adcp_sar u_sar (
      .clk         (MCLK),
      .rst_n       (RST_N),
      .conv        (conv),
      .comp_high   (comp_sync),
      .dac_code    (DAC_CODE),
      .mux_sel     (ANALOG_SELECT),
      .hold_sample (SAMPLE_HOLD)
   );

   // ----------------------------------------------------------------
   // AXI write path: address and data accepted in either order
   // ----------------------------------------------------------------
   logic              aw_full, w_full;
   logic [ADDR_W-1:0] aw_addr;
   logic [31:0]       w_data;
   logic [3:0]        w_strb;
   logic              wr_fire;
   adcp_kind_e        wr_kind;

   assign S_AXI_AWREADY = !aw_full && !S_AXI_BVALID;
   assign S_AXI_WREADY  = !w_full && !S_AXI_BVALID;
   assign wr_fire       = aw_full && w_full && !S_AXI_BVALID;
   assign wr_kind       = addr_kind(aw_addr);

   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         aw_full      <= 1'b0;
         w_full       <= 1'b0;
         aw_addr      <= '0;
         w_data       <= 32'h0000_0000;
         w_strb       <= 4'h0;
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP  <= RESP_OKAY;
      end else begin
         if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_full <= 1'b1;
            aw_addr <= S_AXI_AWADDR;
         end
         if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_full <= 1'b1;
            w_data <= S_AXI_WDATA;
            w_strb <= S_AXI_WSTRB;
         end
         if (wr_fire) begin
            aw_full      <= 1'b0;
            w_full       <= 1'b0;
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP  <= (wr_kind == KIND_NONE) ? RESP_SLVERR : RESP_OKAY;
         end else if (S_AXI_BVALID && S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Control register and run state
   // ----------------------------------------------------------------
   logic ctl_write, sw_start, sw_stop, trig_start, go;
   logic [1:0] last_pos;

   assign ctl_write  = wr_fire && (wr_kind == KIND_CTRL) && w_strb[0];
   assign sw_start   = ctl_write && w_data[CTL_START];
   assign sw_stop    = ctl_write && !w_data[CTL_START];
   assign trig_start = trig_en && trig_sync && !trig_prev && !running;
   assign go         = (sw_start && !running) || trig_start;
   assign last_pos   = chan_cfg[1:0];

   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         chan_cfg  <= 3'h0;
         scan_mode <= 1'b0;
         trig_en   <= 1'b0;
         irq_en    <= 1'b0;
      end else if (ctl_write) begin
         chan_cfg  <= w_data[CTL_CHAN_LSB +: 3];
         scan_mode <= w_data[CTL_SCAN];
         trig_en   <= w_data[CTL_TRIG_EN];
         irq_en    <= w_data[CTL_IRQ_EN];
      end
   end

   // Next input; a config write with START set while running changes the mode and wrap point of the running sequence
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         running  <= 1'b0;
         cur_chan <= 3'h0;
      end else if (go) begin
         running  <= 1'b1;
         cur_chan <= (ctl_write ? w_data[CTL_SCAN] : scan_mode)
                     ? {(ctl_write ? w_data[CTL_CHAN_LSB + 2] : chan_cfg[2]), 2'b00}
                     : (ctl_write ? w_data[CTL_CHAN_LSB +: 3] : chan_cfg);
      end else if (sw_stop) begin
         running <= 1'b0;
      end else if (conv.done && running) begin
         if (!scan_mode) begin
            running <= 1'b0;
         end else if (cur_chan[1:0] == last_pos) begin
            cur_chan <= {cur_chan[2], 2'b00};
         end else begin
            cur_chan <= cur_chan + 3'h1;
         end
      end
   end

   // Issue one start per conversion; done gate stops a spare start in single mode
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         start_q <= 1'b0;
      end else begin
         start_q <= running && !conv.busy && !start_q && !conv.done && !sw_stop;
      end
   end

   assign conv.start = start_q;
   assign conv.chan  = cur_chan;

   // ----------------------------------------------------------------
   // Result registers
   // ----------------------------------------------------------------
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         for (int i = 0; i < NUM_RESULTS; i++) begin
            results[i] <= RESULT_RESET;
         end
      end else if (conv.done) begin
         results[ANALOG_SELECT[1:0]] <= {conv.result, {RESULT_SHIFT{1'b0}}};
      end
   end

   // ----------------------------------------------------------------
   // Completion flag and interrupt
   // ----------------------------------------------------------------
   logic done_clear;
   assign done_clear = wr_fire && (wr_kind == KIND_STAT) && w_strb[0] && w_data[STS_DONE];

   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         done_flag <= 1'b0;
      end else begin
         done_flag <= conv.done || (done_flag && !done_clear);
      end
   end

   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         CONVERSION_DONE_INTERRUPT <= 1'b0;
      end else begin
         CONVERSION_DONE_INTERRUPT <= irq_en && (conv.done || (done_flag && !done_clear));
      end
   end

   // ----------------------------------------------------------------
   // AXI read path
   // ----------------------------------------------------------------
   adcp_kind_e  rd_kind;
   logic [1:0]  rd_idx;
   logic [31:0] rd_word;

   assign rd_kind       = addr_kind(S_AXI_ARADDR);
   assign rd_idx        = addr_index(S_AXI_ARADDR);
   assign S_AXI_ARREADY = !S_AXI_RVALID;

   always_comb begin
      rd_word = 32'h0000_0000;
      case (rd_kind)
         KIND_WORD:  rd_word[15:0] = results[rd_idx];
         KIND_UPPER: rd_word[7:0]  = results[rd_idx][15:8];
         KIND_LOWER: rd_word[7:0]  = low_latch;
         KIND_CTRL:  rd_word[CTL_W-1:0] = {running, irq_en, trig_en, scan_mode, chan_cfg};
         KIND_STAT: begin
            rd_word[STS_DONE] = done_flag;
            rd_word[STS_BUSY] = running || conv.busy;
         end
         default:    rd_word = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA  <= 32'h0000_0000;
         S_AXI_RRESP  <= RESP_OKAY;
      end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
         S_AXI_RVALID <= 1'b1;
         S_AXI_RDATA  <= rd_word;
         S_AXI_RRESP  <= (rd_kind == KIND_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
         S_AXI_RVALID <= 1'b0;
      end
   end

   // Byte path relies on upper-then-lower order by software
   // latch low byte
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         low_latch <= 8'h00;
      end else if (S_AXI_ARVALID && S_AXI_ARREADY && rd_kind == KIND_UPPER) begin
         low_latch <= results[rd_idx][7:0];
      end
   end

endmodule

// ---- rtl/adcp_pkg.sv ----
// Constants shared by the converter control block and its SAR engine.
// Assumes a 20 MHz system clock and a 32-bit AXI4-Lite register port.
package adcp_pkg;

   // ----------------------------------------------------------------
   // Converter geometry
   // ----------------------------------------------------------------
   localparam int          RES_BITS     = 10;
   localparam int          NUM_RESULTS  = 4;
   localparam int          NUM_INPUTS   = 8;
   localparam int          RESULT_SHIFT = 6;
   localparam logic [15:0] RESULT_RESET = 16'h0000;

   // ----------------------------------------------------------------
   // Timing: least conversion time, rounded up to whole clocks
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_PS  = 50000;
   localparam int CONV_TIME_PS   = 3500000;
   localparam int CONV_CYCLES    = (CONV_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int BIT_CYCLES     = 6;
   localparam int SAMPLE_CYCLES  = CONV_CYCLES - RES_BITS * BIT_CYCLES;

   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam int          ADDR_W        = 8;
   localparam logic [7:0]  OFS_RESULT_A  = 8'h00;
   localparam logic [7:0]  OFS_UPPER_A   = 8'h10;
   localparam logic [7:0]  OFS_LOWER_A   = 8'h20;
   localparam logic [7:0]  OFS_CONTROL   = 8'h30;
   localparam logic [7:0]  OFS_STATUS    = 8'h34;
   localparam logic [7:0]  GROUP_MASK    = 8'hf0;
   localparam int          IDX_LSB       = 2;

   // Control register fields
   localparam int CTL_CHAN_LSB = 0;
   localparam int CTL_SCAN     = 3;
   localparam int CTL_TRIG_EN  = 4;
   localparam int CTL_IRQ_EN   = 5;
   localparam int CTL_START    = 6;
   localparam int CTL_W        = 7;

   // Status register fields
   localparam int STS_DONE = 0;
   localparam int STS_BUSY = 1;

   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [5:0] {
      KIND_WORD  = 6'b000001,
      KIND_UPPER = 6'b000010,
      KIND_LOWER = 6'b000100,
      KIND_CTRL  = 6'b001000,
      KIND_STAT  = 6'b010000,
      KIND_NONE  = 6'b100000
   } adcp_kind_e;

   typedef enum logic [2:0] {
      SAR_IDLE    = 3'b001,
      SAR_SAMPLE  = 3'b010,
      SAR_CONVERT = 3'b100
   } adcp_sar_e;

endpackage

// ---- rtl/adcp_conv_if.sv ----
// Handshake between the control block and the SAR engine.
// Both ends run on the one system clock.
`timescale 1ns/1ps
interface adcp_conv_if;
   import adcp_pkg::*;
   logic                start;
   logic [2:0]          chan;
   logic                busy;
   logic                done;
   logic [RES_BITS-1:0] result;

   modport ctrl (output start, output chan, input busy, input done, input result);
   modport sar  (input start, input chan, output busy, output done, output result);
endinterface

// ---- rtl/adcp_sar.sv ----
// Successive-approximation engine: sample phase, then one bit per six clocks.
// Expects a comparator level already synchronised to the system clock.
`timescale 1ns/1ps
module adcp_sar
   import adcp_pkg::*;
(
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                rst_n,
   // Control side
   adcp_conv_if.sar                 conv,
   // Analog front end
   input  wire logic                comp_high,
   output logic [RES_BITS-1:0]      dac_code,
   output logic [2:0]               mux_sel,
   output logic                     hold_sample
);

   localparam logic [7:0] SAMPLE_LAST = 8'(SAMPLE_CYCLES - 1);
   localparam logic [7:0] BIT_LAST    = 8'(BIT_CYCLES - 1);
   localparam logic [3:0] TOP_BIT     = 4'(RES_BITS - 1);
   localparam logic [RES_BITS-1:0] ONE = RES_BITS'(1);

   adcp_sar_e           state;
   logic [7:0]          step;
   logic [3:0]          bit_n;
   logic [RES_BITS-1:0] kept;

   assign conv.busy   = (state != SAR_IDLE);
   assign hold_sample = (state == SAR_SAMPLE);

   // Comparator high means input at or above the trial code: keep the bit
   always_comb begin
      kept = comp_high ? dac_code : (dac_code & ~(ONE << bit_n));
   end

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   // fixed conversion length
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state       <= SAR_IDLE;
         step        <= 8'h00;
         bit_n       <= 4'h0;
         dac_code    <= '0;
         mux_sel     <= 3'h0;
         conv.done   <= 1'b0;
         conv.result <= '0;
      end else begin
         conv.done <= 1'b0;
         case (state)
            SAR_IDLE: begin
               if (conv.start) begin
                  state   <= SAR_SAMPLE;
                  mux_sel <= conv.chan;
                  step    <= 8'h00;
               end
            end
            SAR_SAMPLE: begin
               if (step == SAMPLE_LAST) begin
                  state    <= SAR_CONVERT;
                  step     <= 8'h00;
                  bit_n    <= TOP_BIT;
                  dac_code <= ONE << TOP_BIT;
               end else begin
                  step <= step + 8'h01;
               end
            end
            SAR_CONVERT: begin
               if (step == BIT_LAST) begin
                  step <= 8'h00;
                  if (bit_n == 4'h0) begin
                     conv.result <= kept;
                     conv.done   <= 1'b1;
                     state       <= SAR_IDLE;
                  end else begin
                     dac_code <= kept | (ONE << (bit_n - 4'h1));
                     bit_n    <= bit_n - 4'h1;
                  end
               end else begin
                  step <= step + 8'h01;
               end
            end
            default: state <= SAR_IDLE;
         endcase
      end
   end

endmodule

// ---- sim/adcp_afe_model.sv ----
// Analog front end model: eight held input levels, mux, DAC and comparator.
// Levels come from the bench and must stay put while a conversion runs.
`timescale 1ns/1ps
module adcp_afe_model
   import adcp_pkg::*;
(
   // Pins of the converter block
   input  wire logic [RES_BITS-1:0]            dac_code,
   input  wire logic [2:0]                     select,
   output logic                                comp_high,
   // Levels set by the bench
   input  wire logic [NUM_INPUTS*RES_BITS-1:0] levels
);
   // Ideal comparator, so a correct search lands exactly on the level
   assign comp_high = (levels[select*RES_BITS +: RES_BITS] >= dac_code);
endmodule

// ---- sim/adcp_chk.sv ----
// Port-level checks of the converter block's register port and conversion timing.
// Bound to adcp_top; one clock domain with synchronous active-low reset.
`timescale 1ns/1ps
module adcp_chk
   import adcp_pkg::*;
(
   // Clock and reset
   input  wire logic              MCLK,
   input  wire logic              RST_N,
   // AXI4-Lite
   input  wire logic              S_AXI_AWVALID,
   input  wire logic              S_AXI_AWREADY,
   input  wire logic              S_AXI_WVALID,
   input  wire logic              S_AXI_WREADY,
   input  wire logic              S_AXI_BVALID,
   input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
   input  wire logic              S_AXI_ARVALID,
   input  wire logic              S_AXI_ARREADY,
   input  wire logic [31:0]       S_AXI_RDATA,
   input  wire logic              S_AXI_RVALID,
   input  wire logic              S_AXI_RREADY,
   // Front end
   input  wire logic              SAMPLE_HOLD
);
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RST_N);

   logic [ADDR_W-1:0] rd_addr;
   logic [7:0]        since_sample;

   always_ff @(posedge MCLK) begin
      if (!RST_N)
         rd_addr <= '0;
      else if (S_AXI_ARVALID && S_AXI_ARREADY)
         rd_addr <= S_AXI_ARADDR;
   end

   // Saturates, so the first conversion after reset is never judged
   always_ff @(posedge MCLK) begin
      if (!RST_N)
         since_sample <= 8'hff;
      else if ($rose(SAMPLE_HOLD))
         since_sample <= 8'h01;
      else if (since_sample != 8'hff)
         since_sample <= since_sample + 8'h01;
   end

   sequence s_hold_ten;
      SAMPLE_HOLD[*8] ##1 SAMPLE_HOLD ##1 SAMPLE_HOLD;
   endsequence

   // Both halves sit in holding flops one cycle before the write lands
   AST_B_AFTER_WRITE: assert property (
      S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID)
      else $error("write response missing");
   AST_W_BLOCKED: assert property (
      S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
      else $error("write taken during response");
   AST_R_AFTER_ADDR: assert property (
      S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
      else $error("read data missing");
   AST_AR_BLOCKED: assert property (
      S_AXI_RVALID |-> !S_AXI_ARREADY)
      else $error("read taken during data");
   AST_R_DROP: assert property (
      S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
      else $error("read data not released");
   AST_WORD_VIEW: assert property (
      S_AXI_RVALID && rd_addr[7:4] == 4'h0 |-> S_AXI_RDATA[5:0] == 6'h00
      && S_AXI_RDATA[31:16] == 16'h0000)
      else $error("result word has stray bits");
   AST_UPPER_VIEW: assert property (
      S_AXI_RVALID && rd_addr[7:4] == 4'h1 |-> S_AXI_RDATA[31:8] == 24'h000000)
      else $error("upper byte view wider than a byte");
   AST_SAMPLE_LEN: assert property (
      $rose(SAMPLE_HOLD) |-> s_hold_ten ##1 !SAMPLE_HOLD)
      else $error("sample phase length wrong");
   AST_CONV_GAP: assert property (
      $rose(SAMPLE_HOLD) |-> since_sample >= 8'd70)
      else $error("conversions closer than allowed");
endmodule

// ---- sim/tb_adcp_top.sv ----
// Self-checking bench: AXI4-Lite master, analog model, reference results.
// Assumes the register map and conversion timing of the design's package.
`timescale 1ns/1ps
module tb_adcp_top
   import adcp_pkg::*;
;
   logic        mclk = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  awaddr = 8'h00;
   logic [7:0]  araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0, ext_trig = 1'b0;
   logic [79:0] levels = 80'h0;
   logic [31:0] seed = 32'h000081f4;
   wire  [1:0]  bresp, rresp;
   wire  [31:0] rdata;
   wire  [9:0]  dac;
   wire  [2:0]  asel;
   wire         awready, wready, bvalid, arready, rvalid, irq, sh, comp;
   int          n_fail = 0, n_compared = 0;
   int          exp_res [4] = '{0, 0, 0, 0};

   always #25 mclk = ~mclk;

   adcp_top uut (.MCLK(mclk), .RST_N(rst_n),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
      .EXT_TRIGGER(ext_trig), .COMPARATOR(comp), .DAC_CODE(dac), .ANALOG_SELECT(asel),
      .SAMPLE_HOLD(sh), .CONVERSION_DONE_INTERRUPT(irq));

   adcp_afe_model afe (.dac_code(dac), .select(asel), .comp_high(comp), .levels(levels));

   // ----------------------------------------------------------------
   // Checking and bus tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
      n_compared++;
      if (seen !== expv) begin
         n_fail++;
         $display("BAD t=%0t seen=%h expected=%h", $time, seen, expv);
      end
   endtask

   task automatic tally_and_finish;
      $display("compared %0d mismatched %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic stuck;
      chk(32'h0, 32'h1);
      tally_and_finish;
   endtask

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int   k;
      logic fin, aw_t, w_t;
      @(posedge mclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      fin = 1'b0;
      for (k = 0; k < 50 && !fin; k++) begin
         @(negedge mclk);
         aw_t = awvalid && awready;
         w_t = wvalid && wready;
         fin = bvalid;
         if (fin) chk({30'h0, bresp}, {30'h0, er});
         @(posedge mclk);
         if (aw_t) awvalid <= 1'b0;
         if (w_t) wvalid <= 1'b0;
      end
      bready <= 1'b0;
      if (!fin) stuck;
   endtask

   task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
      int   k;
      logic fin, ar_t;
      @(posedge mclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      fin = 1'b0;
      for (k = 0; k < 50 && !fin; k++) begin
         @(negedge mclk);
         ar_t = arvalid && arready;
         fin = rvalid;
         d = rdata;
         if (fin) chk({30'h0, rresp}, {30'h0, er});
         @(posedge mclk);
         if (ar_t) arvalid <= 1'b0;
      end
      rready <= 1'b0;
      if (!fin) stuck;
   endtask

   task automatic rc(input logic [7:0] a, input logic [31:0] expv);
      logic [31:0] v;
      rd(a, RESP_OKAY, v);
      chk(v, expv);
   endtask

   task automatic poll(input int bitpos, input logic want);
      int          k;
      logic [31:0] v;
      v = {32{~want}};
      for (k = 0; k < 100 && v[bitpos] !== want; k++) rd(OFS_STATUS, RESP_OKAY, v);
      if (v[bitpos] !== want) stuck;
   endtask

   task automatic new_level(input int ch);
      seed = xs(seed);
      @(posedge mclk);
      levels[ch*10 +: 10] <= seed[9:0];
      exp_res[ch % 4] = int'(seed[9:0]) << 6;
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      int          i, ch;
      logic [31:0] v;
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      for (i = 0; i < 4; i++) rc(OFS_RESULT_A + 8'(4*i), 32'h0);
      rc(OFS_STATUS, 32'h0);
      wr(OFS_RESULT_A, 32'hffffffff, RESP_OKAY);
      rc(OFS_RESULT_A, 32'h0);
      wr(8'h40, 32'h1, RESP_SLVERR);
      rd(8'h40, RESP_SLVERR, v);
      chk(v, 32'h0);
      $display("test reset and map done");

      for (ch = 0; ch < 8; ch++) begin
         new_level(ch);
         wr(OFS_CONTROL, {25'h0, 1'b1, 1'(ch & 1), 2'b00, 3'(ch)}, RESP_OKAY);
         poll(STS_DONE, 1'b1);
         rc(OFS_STATUS, 32'h1);
         @(negedge mclk);
         chk({31'h0, irq}, 32'(ch & 1));
         for (i = 0; i < 4; i++) rc(OFS_RESULT_A + 8'(4*i), 32'(exp_res[i]));
         rc(OFS_UPPER_A + 8'(4*(ch%4)), 32'(exp_res[ch%4] >> 8));
         rc(OFS_LOWER_A + 8'(4*(ch%4)), 32'(exp_res[ch%4] & 255));
         wr(OFS_STATUS, 32'h1, RESP_OKAY);
         repeat (2) @(negedge mclk);
         chk({31'h0, irq}, 32'h0);
      end
      $display("test single conversions done");

      for (ch = 4; ch < 7; ch++) new_level(ch);
      wr(OFS_CONTROL, 32'h0000004e, RESP_OKAY);
      repeat (500) @(posedge mclk);
      wr(OFS_CONTROL, 32'h0, RESP_OKAY);
      poll(STS_BUSY, 1'b0);
      for (i = 0; i < 4; i++) rc(OFS_RESULT_A + 8'(4*i), 32'(exp_res[i]));
      wr(OFS_STATUS, 32'h1, RESP_OKAY);
      $display("test scan done");

      new_level(1);
      wr(OFS_CONTROL, 32'h00000031, RESP_OKAY);
      @(posedge mclk);
      ext_trig <= 1'b1;
      repeat (4) @(posedge mclk);
      ext_trig <= 1'b0;
      poll(STS_DONE, 1'b1);
      rc(OFS_RESULT_A + 8'h04, 32'(exp_res[1]));
      @(negedge mclk);
      chk({31'h0, irq}, 32'h1);
      wr(OFS_CONTROL, 32'h0, RESP_OKAY);
      $display("test external trigger done");
      tally_and_finish;
   end
endmodule

bind adcp_top adcp_chk u_chk (.MCLK(MCLK), .RST_N(RST_N),
   .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
   .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
   .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
   .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID),
   .S_AXI_RREADY(S_AXI_RREADY), .SAMPLE_HOLD(SAMPLE_HOLD));
